// [src/chgcfg_regs.sv]
// Charger configuration register bank with safety timers and status flags
`timescale 1ns/1ps
`include "chgcfg_cfg.svh"
//
// Contract
// - Fast-charge timer code selects 4, 5, 6 or 8 hours; resets to 10b.
// - Timer enable 0 disables precharge and fast timers; resets to 1.
// - Thermistor bit picks 100k curve at 0, 10k at 1; resets to 1.
// - Charger reset held while bit is 1; software writes 1 then 0.
// - Termination bit 1 blocks current-based termination; charger stays on.
// - Suspend bit 1 freezes both timers; resets to 0.
// - Charger enable bit turns charger off at 0, on at 1; resets 1.
// - Halving bit divides timer clock by 2 while thermal or path loop active.
// - Precharge threshold 2.9 V at 0, 2.5 V at 1; resets 0.
// - Power-path threshold 3.5, 3.75, 4, 4.25 V; resets 11b.
// - Termination current is factor times charge current; factor resets 01b.
// - Temperature window 0 to 45 C at 0, 0 to 60 C at 1.
// - Low four timing bits are spare, read/write, reset zero, no effect.
// - Timer expiry sets read-only timeout flag and stops charging.
// - Read-only flags show thermal loop and power-path loop activity.
module chgcfg_regs
    import chgcfg_pkg::*;
#(
    parameter int TICK_CYCLES = `CHGCFG_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Register access from the serial interface
    input  wire logic       reg_write,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Analog charger status
    input  wire logic       thermal_loop_active,
    input  wire logic       power_path_loop_active,
    input  wire logic       battery_present,
    input  wire logic       battery_above_precharge,
    input  wire logic       current_below_stop,
    // Charger controls
    output logic            charger_reset_active,
    output logic            charger_enable,
    output logic            thermistor_curve_select,
    output logic            charge_temp_window,
    output logic            precharge_threshold_select,
    output logic      [1:0] regulation_voltage_select,
    output logic      [1:0] charge_current_select,
    output logic      [1:0] power_path_threshold,
    output logic      [1:0] stop_current_factor,
    output logic            charging,
    output logic            charge_timeout_flag,
    output logic            precharge_timeout_flag,
    output logic            thermal_loop_flag,
    output logic            power_path_loop
);
    chgcfg_control_t ctl_reg;
    chgcfg_control_t ctl_next;
    chgcfg_timing_t  tim_reg;
    chgcfg_timing_t  tim_next;
    chgcfg_limits_t  lim_reg;
    chgcfg_limits_t  lim_next;
    chgcfg_phase_t   phase_reg;
    chgcfg_phase_t   phase_next;
    logic            tout_reg;
    logic            tout_next;
    logic            ptout_reg;
    logic            ptout_next;
    logic            thermal_loop_flag_reg;
    logic            power_path_loop_reg;
    logic            thermal_loop_flag_next;
    logic            power_path_loop_next;
    logic [7:0]      rdata_reg;
    logic [7:0]      rdata_next;
    logic            tick;
    logic            halve;
    logic            timers_run;
    logic            restart;
    logic            pre_expired;
    logic            fast_expired;
    logic [15:0]     fast_limit;
    logic [15:0]     pre_limit;

    function automatic logic [15:0] fast_secs(input logic [1:0] code);
        case (code)
            2'b00:   fast_secs = 16'(`CHGCFG_FAST_4H_S);
            2'b01:   fast_secs = 16'(`CHGCFG_FAST_5H_S);
            2'b10:   fast_secs = 16'(`CHGCFG_FAST_6H_S);
            default: fast_secs = 16'(`CHGCFG_FAST_8H_S);
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Register writes; the spare low bits of the timing register store freely
    always_comb begin
        ctl_next = ctl_reg;
        tim_next = tim_reg;
        lim_next = lim_reg;
        if (reg_write && hit(reg_addr, `CHGCFG_OFS_CONTROL)) begin
            ctl_next = chgcfg_control_t'(reg_wdata);
        end
        if (reg_write && hit(reg_addr, `CHGCFG_OFS_TIMING_VOLT)) begin
            tim_next = chgcfg_timing_t'(reg_wdata);
        end
        if (reg_write && hit(reg_addr, `CHGCFG_OFS_CURR_LIMITS)) begin
            lim_next = chgcfg_limits_t'(reg_wdata);
        end
    end

    // Reads of the status byte return live flags; flags are read-only
    always_comb begin
        case (reg_addr)
            `CHGCFG_OFS_STATUS:      rdata_next = {thermal_loop_flag_reg, power_path_loop_reg, 3'h0, tout_reg,
                                                   ptout_reg, 1'b0};
            `CHGCFG_OFS_CONTROL:     rdata_next = ctl_reg;
            `CHGCFG_OFS_TIMING_VOLT: rdata_next = tim_reg;
            `CHGCFG_OFS_CURR_LIMITS: rdata_next = lim_reg;
            default:                 rdata_next = 8'h00;
        endcase
    end

    // Charger reset or disable restarts the algorithm and clears timeouts
    assign restart    = ctl_reg.charger_reset || !ctl_reg.charger_on;
    assign timers_run = ctl_reg.safety_timers_on && !ctl_reg.timer_freeze;
    assign halve      = tim_reg.timer_clock_halving &&
                        (thermal_loop_flag_reg || power_path_loop_reg);
    assign fast_limit = fast_secs(ctl_reg.fast_timer_select);
    assign pre_limit  = lim_reg.precharge_time_select ?
                        16'(`CHGCFG_PRE_60M_S) : 16'(`CHGCFG_PRE_30M_S);

    chgcfg_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clock (clock),
        .rst   (rst),
        .halve (halve),
        .tick  (tick)
    );

    chgcfg_timer u_pre_timer (
        .clock   (clock),
        .rst     (rst),
        .clear   (restart || phase_reg != CHGCFG_PRECHARGE),
        .run     (timers_run),
        .tick    (tick),
        .limit   (pre_limit),
        .expired (pre_expired)
    );

    chgcfg_timer u_fast_timer (
        .clock   (clock),
        .rst     (rst),
        .clear   (restart || phase_reg != CHGCFG_FAST),
        .run     (timers_run),
        .tick    (tick),
        .limit   (fast_limit),
        .expired (fast_expired)
    );

    // Charge sequence: precharge, fast charge, done
    always_comb begin
        phase_next = phase_reg;
        tout_next  = tout_reg;
        ptout_next = ptout_reg;
        if (restart) begin
            phase_next = CHGCFG_IDLE;
            tout_next  = 1'b0;
            ptout_next = 1'b0;
        end else begin
            case (phase_reg)
                CHGCFG_IDLE: begin
                    if (battery_present && !tout_reg) begin
                        phase_next = battery_above_precharge ? CHGCFG_FAST
                                                             : CHGCFG_PRECHARGE;
                    end
                end
                CHGCFG_PRECHARGE: begin
                    if (timers_run && pre_expired) begin
                        tout_next  = 1'b1;
                        ptout_next = 1'b1;
                        phase_next = CHGCFG_DONE;
                    end else if (battery_above_precharge) begin
                        phase_next = CHGCFG_FAST;
                    end
                end
                CHGCFG_FAST: begin
                    if (timers_run && fast_expired) begin
                        tout_next  = 1'b1;
                        phase_next = CHGCFG_DONE;
                    end else if (!ctl_reg.term_disable && current_below_stop) begin
                        phase_next = CHGCFG_DONE;
                    end
                end
                CHGCFG_DONE: begin
                    phase_next = CHGCFG_DONE;
                end
                default: begin
                    phase_next = CHGCFG_IDLE;
                end
            endcase
        end
    end

    // Loop status copies; one cycle of lag is negligible against one-second ticks
    always_comb begin
        thermal_loop_flag_next = thermal_loop_active;
        power_path_loop_next = power_path_loop_active;
    end

    // Configuration registers
    always_ff @(posedge clock) begin
        if (rst) begin
            ctl_reg <= chgcfg_control_t'(`CHGCFG_RST_CONTROL);
            tim_reg <= chgcfg_timing_t'(`CHGCFG_RST_TIMING_VOLT);
            lim_reg <= chgcfg_limits_t'(`CHGCFG_RST_CURR_LIMITS);
        end else begin
            ctl_reg <= ctl_next;
            tim_reg <= tim_next;
            lim_reg <= lim_next;
        end
    end

    // Charge sequence and sticky timeout flags
    always_ff @(posedge clock) begin
        if (rst) begin
            phase_reg <= CHGCFG_IDLE;
            tout_reg  <= 1'b0;
            ptout_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            tout_reg  <= tout_next;
            ptout_reg <= ptout_next;
        end
    end

    // Loop flags and read data
    always_ff @(posedge clock) begin
        if (rst) begin
            thermal_loop_flag_reg  <= 1'b0;
            power_path_loop_reg  <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            thermal_loop_flag_reg  <= thermal_loop_flag_next;
            power_path_loop_reg  <= power_path_loop_next;
            rdata_reg <= rdata_next;
        end
    end

    // Configuration fields go straight from flops to the analog loops
    assign reg_rdata                  = rdata_reg;
    assign charger_reset_active       = ctl_reg.charger_reset;
    assign charger_enable             = ctl_reg.charger_on;
    assign thermistor_curve_select    = ctl_reg.thermistor_curve_select;
    assign charge_temp_window         = lim_reg.charge_temp_window;
    assign precharge_threshold_select = tim_reg.precharge_threshold_select;
    assign regulation_voltage_select  = tim_reg.regulation_voltage_select;
    assign charge_current_select      = lim_reg.charge_current_select;
    assign power_path_threshold       = lim_reg.power_path_threshold;
    assign stop_current_factor        = lim_reg.stop_current_factor;
    assign charging = (phase_reg == CHGCFG_PRECHARGE) ||
                      (phase_reg == CHGCFG_FAST);
    assign charge_timeout_flag        = tout_reg;
    assign precharge_timeout_flag     = ptout_reg;
    assign thermal_loop_flag          = thermal_loop_flag_reg;
    assign power_path_loop            = power_path_loop_reg;
endmodule // chgcfg_regs

// [src/chgcfg_cfg.svh]
// Register offsets, field positions, reset values and timing counts of the charger config bank
`ifndef CHGCFG_CFG_SVH
`define CHGCFG_CFG_SVH

`define CHGCFG_OFS_CONTROL      8'h04
`define CHGCFG_OFS_TIMING_VOLT  8'h05
`define CHGCFG_OFS_CURR_LIMITS  8'h06
`define CHGCFG_OFS_STATUS       8'h03

`define CHGCFG_RST_CONTROL      8'hb1
`define CHGCFG_RST_TIMING_VOLT  8'h80
`define CHGCFG_RST_CURR_LIMITS  8'hb2

// Field positions within the control register
`define CHGCFG_CTL_TIMER_LSB    6
`define CHGCFG_CTL_TMR_ON       5
`define CHGCFG_CTL_NTC          4
`define CHGCFG_CTL_RESET        3
`define CHGCFG_CTL_TERM         2
`define CHGCFG_CTL_FREEZE       1
`define CHGCFG_CTL_CHG_ON       0

// Status flag positions
`define CHGCFG_ST_THERMAL       7
`define CHGCFG_ST_POWER_PATH    6
`define CHGCFG_ST_TIMEOUT       2
`define CHGCFG_ST_PRE_TIMEOUT   1

// Timer clock: one tick per second at 50 MHz
`define CHGCFG_CLK_HZ           50000000
`define CHGCFG_TICK_CYCLES      (`CHGCFG_CLK_HZ)

// Timer limits in seconds
`define CHGCFG_FAST_4H_S        14400
`define CHGCFG_FAST_5H_S        18000
`define CHGCFG_FAST_6H_S        21600
`define CHGCFG_FAST_8H_S        28800
`define CHGCFG_PRE_30M_S        1800
`define CHGCFG_PRE_60M_S        3600

`endif

// [src/chgcfg_pkg.sv]
// Types shared by the charger configuration bank
package chgcfg_pkg;

    typedef struct packed {
        logic [1:0] fast_timer_select;
        logic       safety_timers_on;
        logic       thermistor_curve_select;
        logic       charger_reset;
        logic       term_disable;
        logic       timer_freeze;
        logic       charger_on;
    } chgcfg_control_t;

    typedef struct packed {
        logic       timer_clock_halving;
        logic       precharge_threshold_select;
        logic [1:0] regulation_voltage_select;
        logic [3:0] spare;
    } chgcfg_timing_t;

    typedef struct packed {
        logic [1:0] charge_current_select;
        logic [1:0] power_path_threshold;
        logic       precharge_time_select;
        logic [1:0] stop_current_factor;
        logic       charge_temp_window;
    } chgcfg_limits_t;

    typedef enum logic [1:0] {
        CHGCFG_IDLE,
        CHGCFG_PRECHARGE,
        CHGCFG_FAST,
        CHGCFG_DONE
    } chgcfg_phase_t;

endpackage

// [src/chgcfg_tick.sv]
// Timer time-base: one-second ticks, halved rate when requested
`timescale 1ns/1ps
`include "chgcfg_cfg.svh"
module chgcfg_tick
    import chgcfg_pkg::*;
#(
    parameter int TICK_CYCLES = `CHGCFG_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Control
    input  wire logic halve,
    // Tick out
    output logic      tick
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic        half_reg;
    logic        half_next;
    logic        wrap;

    assign wrap = (count_reg == 32'(TICK_CYCLES - 1));
    assign tick = wrap && (!halve || half_reg);

    always_comb begin
        count_next = wrap ? 32'h0 : count_reg + 32'h1;
        half_next  = half_reg;
        if (wrap) begin
            half_next = halve ? !half_reg : 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg <= 32'h0;
            half_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            half_reg  <= half_next;
        end
    end
endmodule // chgcfg_tick

// [src/chgcfg_timer.sv]
// Seconds counter that flags expiry at a selectable limit
`timescale 1ns/1ps
module chgcfg_timer (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Control
    input  wire logic        clear,
    input  wire logic        run,
    input  wire logic        tick,
    input  wire logic [15:0] limit,
    // Result
    output logic             expired
);
    logic [15:0] secs_reg;
    logic [15:0] secs_next;

    assign expired = (secs_reg >= limit);

    always_comb begin
        secs_next = secs_reg;
        if (clear) begin
            secs_next = 16'h0;
        end else if (run && tick && !expired) begin
            secs_next = secs_reg + 16'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            secs_reg <= 16'h0;
        end else begin
            secs_reg <= secs_next;
        end
    end
endmodule // chgcfg_timer

// [verif/chgcfg_regs_checker.sv]
// Assertion checker for the charger configuration register bank
`timescale 1ns/1ps
module chgcfg_regs_checker #(
    parameter int TICK_CYCLES = 2
) (
    // Clock, reset and register access
    input logic       clock,
    input logic       rst,
    input logic       reg_write,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    // Loop inputs
    input logic       thermal_loop_active,
    input logic       power_path_loop_active,
    // Charger controls and status
    input logic       charger_reset_active,
    input logic       charger_enable,
    input logic       thermistor_curve_select,
    input logic       charge_temp_window,
    input logic       precharge_threshold_select,
    input logic [1:0] regulation_voltage_select,
    input logic [1:0] charge_current_select,
    input logic [1:0] power_path_threshold,
    input logic [1:0] stop_current_factor,
    input logic       charging,
    input logic       charge_timeout_flag,
    input logic       precharge_timeout_flag,
    input logic       thermal_loop_flag,
    input logic       power_path_loop
);
    logic ctl_wr, tv_wr, lim_wr;
    assign ctl_wr = reg_write && reg_addr == 8'h04;
    assign tv_wr  = reg_write && reg_addr == 8'h05;
    assign lim_wr = reg_write && reg_addr == 8'h06;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_RESET_BIT: assert property (
        ctl_wr |=> charger_reset_active == $past(reg_wdata[3])) else $error("reset bit");
    AST_ENABLE_BITS: assert property (
        ctl_wr |=> {thermistor_curve_select, charger_enable} == $past({reg_wdata[4], reg_wdata[0]}))
        else $error("enable bits");
    AST_TIMING_FIELDS: assert property (
        tv_wr |=> {precharge_threshold_select, regulation_voltage_select} == $past(reg_wdata[6:4]))
        else $error("timing fields");
    AST_LIMIT_FIELDS: assert property (
        lim_wr |=> {charge_current_select, power_path_threshold, stop_current_factor,
        charge_temp_window} == $past({reg_wdata[7:4], reg_wdata[2:0]})) else $error("limit fields");
    AST_STOPPED: assert property (
        (charger_reset_active || !charger_enable) |=> !charging && !charge_timeout_flag)
        else $error("charger not stopped");
    AST_TIMEOUT_STOPS: assert property (
        charge_timeout_flag |=> !charging) else $error("charging after timeout");
    AST_PRE_BOTH: assert property (
        precharge_timeout_flag |-> charge_timeout_flag) else $error("precharge flag alone");
    AST_LOOP_COPY: assert property (
        $past(!rst) |-> {thermal_loop_flag, power_path_loop} ==
        $past({thermal_loop_active, power_path_loop_active})) else $error("loop flags");
    AST_STATUS_READ: assert property (
        reg_addr == 8'h03 |=> reg_rdata == {$past({thermal_loop_flag, power_path_loop}), 3'h0,
        $past({charge_timeout_flag, precharge_timeout_flag}), 1'b0}) else $error("status read");

    cover property ($rose(charge_timeout_flag));
    cover property ($rose(precharge_timeout_flag));
    cover property (ctl_wr && reg_wdata[3]);
endmodule // chgcfg_regs_checker

bind chgcfg_regs chgcfg_regs_checker #(
    .TICK_CYCLES (TICK_CYCLES)
) u_chk (
    .clock                      (clock),
    .rst                        (rst),
    .reg_write                  (reg_write),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_rdata                  (reg_rdata),
    .thermal_loop_active        (thermal_loop_active),
    .power_path_loop_active     (power_path_loop_active),
    .charger_reset_active       (charger_reset_active),
    .charger_enable             (charger_enable),
    .thermistor_curve_select    (thermistor_curve_select),
    .charge_temp_window         (charge_temp_window),
    .precharge_threshold_select (precharge_threshold_select),
    .regulation_voltage_select  (regulation_voltage_select),
    .charge_current_select      (charge_current_select),
    .power_path_threshold       (power_path_threshold),
    .stop_current_factor        (stop_current_factor),
    .charging                   (charging),
    .charge_timeout_flag        (charge_timeout_flag),
    .precharge_timeout_flag     (precharge_timeout_flag),
    .thermal_loop_flag          (thermal_loop_flag),
    .power_path_loop            (power_path_loop)
);

// [verif/chgcfg_regs_test.sv]
// Self-checking testbench for the charger configuration register bank
`timescale 1ns/1ps
module chgcfg_regs_test;
    import chgcfg_pkg::*;
    // Short tick keeps hour-long timers within the run
    localparam int TICK = 2;
    logic       clock, rst, reg_write;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       thermal_loop_active, power_path_loop_active, battery_present;
    logic       battery_above_precharge, current_below_stop, charger_reset_active;
    logic       charger_enable, thermistor_curve_select, charge_temp_window;
    logic       precharge_threshold_select, charging, charge_timeout_flag;
    logic       precharge_timeout_flag, thermal_loop_flag, power_path_loop;
    logic [1:0] regulation_voltage_select, charge_current_select;
    logic [1:0] power_path_threshold, stop_current_factor;
    int         n_mismatch = 0, n_tests = 0, cycles = 0;

    chgcfg_regs #(
        .TICK_CYCLES (TICK)
    ) DUT (
        .clock                      (clock),
        .rst                        (rst),
        .reg_write                  (reg_write),
        .reg_addr                   (reg_addr),
        .reg_wdata                  (reg_wdata),
        .reg_rdata                  (reg_rdata),
        .thermal_loop_active        (thermal_loop_active),
        .power_path_loop_active     (power_path_loop_active),
        .battery_present            (battery_present),
        .battery_above_precharge    (battery_above_precharge),
        .current_below_stop         (current_below_stop),
        .charger_reset_active       (charger_reset_active),
        .charger_enable             (charger_enable),
        .thermistor_curve_select    (thermistor_curve_select),
        .charge_temp_window         (charge_temp_window),
        .precharge_threshold_select (precharge_threshold_select),
        .regulation_voltage_select  (regulation_voltage_select),
        .charge_current_select      (charge_current_select),
        .power_path_threshold       (power_path_threshold),
        .stop_current_factor        (stop_current_factor),
        .charging                   (charging),
        .charge_timeout_flag        (charge_timeout_flag),
        .precharge_timeout_flag     (precharge_timeout_flag),
        .thermal_loop_flag          (thermal_loop_flag),
        .power_path_loop            (power_path_loop)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        @(negedge clock);
        d = reg_rdata;
    endtask

    // Pulse the reset bit so every charge cycle starts from idle with cleared timers
    task automatic restart(input logic [7:0] c);
        wr(8'h04, c | 8'h08);
        chk(charger_reset_active, 1'b1);
        wr(8'h04, c);
    endtask

    // Window allows for restart latency and tick phase
    task automatic expect_expiry(input int secs, input logic pre);
        int k;
        repeat (secs * TICK - 12) @(negedge clock);
        chk(charge_timeout_flag, 1'b0);
        for (k = 0; k < 24 && charge_timeout_flag !== 1'b1; k++) @(negedge clock);
        chk({charge_timeout_flag, precharge_timeout_flag}, {1'b1, pre});
        @(negedge clock);
        chk(charging, 1'b0);
    endtask

    task automatic t_regs;
        logic [7:0] v;
        logic [1:0] c;
        rd(8'h04, v);
        chk(v, 8'hb1);
        rd(8'h05, v);
        chk(v, 8'h80);
        rd(8'h06, v);
        chk(v, 8'hb2);
        wr(8'h03, 8'hff);
        rd(8'h03, v);
        chk(v, 8'h00);
        wr(8'h2a, 8'hff);
        rd(8'h2a, v);
        chk(v, 8'h00);
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr(8'h05, {c[1], c[0], c, 4'h9 ^ {c, c}});
            wr(8'h06, {c, ~c, c[1], c, c[0]});
            rd(8'h05, v);
            chk(v, {c[1], c[0], c, 4'h9 ^ {c, c}});
            chk({precharge_threshold_select, regulation_voltage_select}, {c[0], c});
            chk({charge_current_select, power_path_threshold}, {c, ~c});
            chk({stop_current_factor, charge_temp_window}, {c, c[0]});
        end
        wr(8'h05, 8'h80);
        wr(8'h06, 8'hb2);
    endtask

    task automatic t_precharge;
        logic [7:0] v;
        battery_present = 1'b1;
        restart(8'hb1);
        expect_expiry(1800, 1'b1);
        rd(8'h03, v);
        chk(v, 8'h06);
        thermal_loop_active = 1'b1;
        restart(8'hb1);
        chk(thermal_loop_flag, 1'b1);
        expect_expiry(3600, 1'b1);
        thermal_loop_active = 1'b0;
        // Loop active but halving off: nominal rate, 60 minute limit
        power_path_loop_active = 1'b1;
        wr(8'h05, 8'h00);
        wr(8'h06, 8'hba);
        restart(8'hb1);
        expect_expiry(3600, 1'b1);
        rd(8'h03, v);
        chk(v, 8'h46);
        power_path_loop_active = 1'b0;
        wr(8'h06, 8'hb2);
    endtask

    task automatic t_hold;
        restart(8'hb3);
        repeat (1800 * TICK + 24) @(negedge clock);
        chk({charging, charge_timeout_flag}, 2'b10);
        wr(8'h04, 8'h91);
        repeat (1800 * TICK + 24) @(negedge clock);
        chk({charging, charge_timeout_flag}, 2'b10);
        wr(8'h04, 8'hb1);
        expect_expiry(1800, 1'b1);
    endtask

    task automatic t_fast_term;
        // Low current is ignored in precharge and ends the charge once it moves on
        current_below_stop = 1'b1;
        restart(8'hb1);
        repeat (4) @(negedge clock);
        chk(charging, 1'b1);
        battery_above_precharge = 1'b1;
        repeat (4) @(negedge clock);
        chk({charging, charge_timeout_flag}, 2'b00);
        current_below_stop = 1'b0;
        restart(8'h31);
        expect_expiry(14400, 1'b0);
        current_below_stop = 1'b1;
        restart(8'hb5);
        repeat (20) @(negedge clock);
        chk({charging, charge_timeout_flag}, 2'b10);
        wr(8'h04, 8'hb1);
        repeat (4) @(negedge clock);
        chk({charging, charge_timeout_flag}, 2'b00);
        current_below_stop = 1'b0;
        restart(8'hb1);
        // Idle moves to fast charge one edge after the reset bit clears
        @(negedge clock);
        chk(charging, 1'b1);
        wr(8'h04, 8'ha0);
        @(negedge clock);
        chk({thermistor_curve_select, charger_enable, charging}, 3'h0);
    endtask

    initial begin
        {rst, reg_write, thermal_loop_active, power_path_loop_active} = 4'h8;
        {battery_present, battery_above_precharge, current_below_stop} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (10) @(negedge clock);
        rst = 1'b0;
        t_regs;
        t_precharge;
        t_hold;
        t_fast_term;
        test_done;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_mismatch++;
            test_done;
        end
    end
endmodule // chgcfg_regs_test
